// ==== design/sew_pkg.sv ====
package sew_pkg;
  // Device code matched in the top four bits of the control byte; value is arbitrary.
  localparam logic [3:0] DEV_CODE = 4'hA;
  localparam int ADDR_W = 8;
  localparam int PAGE_LOW_W = 3;
  localparam int PAGE_BYTES = 8;
  localparam int ARRAY_BYTES = 256;
  localparam int BUF_DEPTH = 2;
  localparam int BITS_PER_BYTE = 8;
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // Internally timed write cycle length.
  localparam int WRITE_CYCLE_NS = 20000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int WRITE_CYCLES = WRITE_CYCLE_NS / CLK_PERIOD_NS;
  localparam logic [15:0] WCNT_LOAD = 16'(WRITE_CYCLES);
  localparam logic [15:0] WCNT_RST = 16'h0000;

  typedef enum logic [5:0] {
    SEW_IDLE = 6'b00_0001,
    SEW_CTRL = 6'b00_0010,
    SEW_ADDR = 6'b00_0100,
    SEW_DATA = 6'b00_1000,
    SEW_IGN  = 6'b01_0000,
    SEW_ACK  = 6'b10_0000
  } sew_state_t;
endpackage : sew_pkg

// ==== design/sew_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module sew_sync (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic asyncIn,
  output logic syncOut
);
  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
    end else begin
      meta_ff <= asyncIn;
      sync_ff <= meta_ff;
    end
  end

  assign syncOut = sync_ff;
endmodule : sew_sync
`default_nettype wire

// ==== design/sew_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module sew_fifo (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [15:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [15:0] outData
);
  logic [15:0] mem_ff [sew_pkg::BUF_DEPTH];
  logic wrPtr_ff;
  logic rdPtr_ff;
  logic [1:0] count_ff;
  logic doWr;
  logic doRd;

  assign inReady = (count_ff != 2'(sew_pkg::BUF_DEPTH));
  assign outValid = (count_ff != 2'd0);
  assign outData = mem_ff[rdPtr_ff];
  assign doWr = inValid && inReady;
  assign doRd = outValid && outReady;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_ff <= 1'b0;
      rdPtr_ff <= 1'b0;
      count_ff <= 2'd0;
    end else begin
      if (doWr) begin
        wrPtr_ff <= ~wrPtr_ff;
      end
      if (doRd) begin
        rdPtr_ff <= ~rdPtr_ff;
      end
      count_ff <= count_ff + 2'(doWr) - 2'(doRd);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (doWr) begin
      mem_ff[wrPtr_ff] <= inData;
    end
  end
endmodule : sew_fifo
`default_nettype wire

// ==== design/serial_eeprom_write_path.sv ====
// What this block does
// - Device acknowledges an accepted write control byte on ninth clock.
// - Byte after control byte loads the address pointer and is acknowledged.
// - Byte write: one data byte, acknowledged, then master sends stop.
// - Stop after data starts timed write; no acknowledges while it runs.
// - Page write holds up to eight bytes, committed only after stop.
// - Each data byte increments only the three low pointer bits.
// - More than eight bytes wrap the low bits and overwrite earlier bytes.
// - Busy device does not acknowledge polls; idle device acknowledges them.
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_write_path (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic writeBusy,
  output logic wrValid,
  input wire logic wrReady,
  output logic [7:0] wrAddr,
  output logic [7:0] wrData
);
  logic sclSync;
  logic sdaSync;
  logic sclPrev_ff;
  logic sdaPrev_ff;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;

  sew_sync u_syncScl (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .asyncIn(sclIn),
    .syncOut(sclSync)
  );

  sew_sync u_syncSda (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .asyncIn(sdaIn),
    .syncOut(sdaSync)
  );

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sclPrev_ff <= 1'b1;
      sdaPrev_ff <= 1'b1;
    end else begin
      sclPrev_ff <= sclSync;
      sdaPrev_ff <= sdaSync;
    end
  end

  assign sclRise = sclSync && !sclPrev_ff;
  assign sclFall = !sclSync && sclPrev_ff;
  assign startCond = sclSync && sclPrev_ff && sdaPrev_ff && !sdaSync;
  assign stopCond = sclSync && sclPrev_ff && !sdaPrev_ff && sdaSync;

  sew_pkg::sew_state_t state_ff;
  sew_pkg::sew_state_t retState_ff;
  logic [3:0] bitCnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] addrPtr_ff;
  logic [7:0] pageBuf_ff [sew_pkg::PAGE_BYTES];
  logic [sew_pkg::PAGE_BYTES-1:0] pageVld_ff;
  logic [7:0] pageBase_ff;
  logic dataSeen_ff;
  logic [15:0] wcnt_ff;
  logic busy;
  logic byteDone;
  logic ctrlMatch;
  logic [7:0] rxByte;
  logic commitGo;
  logic [sew_pkg::PAGE_BYTES-1:0] pageVldHold_ff;

  assign busy = (wcnt_ff != sew_pkg::WCNT_RST);
  assign rxByte = {shift_ff[6:0], sdaSync};
  assign byteDone = sclRise && (bitCnt_ff == 4'(sew_pkg::BITS_PER_BYTE - 1));
  assign ctrlMatch = (rxByte[7:4] == sew_pkg::DEV_CODE) && !rxByte[0];

  // Bit counter and shifter; every start resets the bit counter only.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bitCnt_ff <= sew_pkg::BIT_CNT_RST;
      shift_ff <= sew_pkg::BYTE_RST;
    end else if (startCond) begin
      bitCnt_ff <= sew_pkg::BIT_CNT_RST;
    end else if (sclRise && state_ff != sew_pkg::SEW_ACK) begin
      shift_ff <= rxByte;
      bitCnt_ff <= byteDone ? sew_pkg::BIT_CNT_RST : bitCnt_ff + 4'd1;
    end
  end

  // Receive state machine; SEW_ACK drives the ninth-clock acknowledge.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= sew_pkg::SEW_IDLE;
      retState_ff <= sew_pkg::SEW_IDLE;
      sdaOut <= 1'b0;
      sdaOe <= 1'b0;
    end else if (startCond) begin
      state_ff <= sew_pkg::SEW_CTRL;
      sdaOe <= 1'b0;
    end else if (stopCond) begin
      state_ff <= sew_pkg::SEW_IDLE;
      sdaOe <= 1'b0;
    end else begin
      case (state_ff)
        sew_pkg::SEW_CTRL: begin
          if (byteDone) begin
            if (ctrlMatch && !busy) begin
              retState_ff <= sew_pkg::SEW_ADDR;
              state_ff <= sew_pkg::SEW_ACK;
            end else begin
              state_ff <= sew_pkg::SEW_IGN;
            end
          end
        end
        sew_pkg::SEW_ADDR, sew_pkg::SEW_DATA: begin
          if (byteDone) begin
            retState_ff <= sew_pkg::SEW_DATA;
            state_ff <= sew_pkg::SEW_ACK;
          end
        end
        sew_pkg::SEW_ACK: begin
          if (sclFall && !sdaOe) begin
            sdaOe <= 1'b1;
          end else if (sclFall && sdaOe) begin
            sdaOe <= 1'b0;
            state_ff <= retState_ff;
          end
        end
        sew_pkg::SEW_IDLE, sew_pkg::SEW_IGN: begin
          sdaOe <= 1'b0;
        end
        default: begin
          state_ff <= sew_pkg::SEW_IDLE;
          sdaOe <= 1'b0;
        end
      endcase
    end
  end

  logic ackAddr;
  logic ackData;
  assign ackAddr = byteDone && state_ff == sew_pkg::SEW_ADDR && !startCond && !stopCond;
  assign ackData = byteDone && state_ff == sew_pkg::SEW_DATA && !startCond && !stopCond;

  // Address pointer and page buffer capture.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      addrPtr_ff <= sew_pkg::BYTE_RST;
      pageBase_ff <= sew_pkg::BYTE_RST;
      pageVld_ff <= '0;
      dataSeen_ff <= 1'b0;
    end else if (ackAddr) begin
      addrPtr_ff <= rxByte;
      pageBase_ff <= rxByte;
      pageVld_ff <= '0;
      dataSeen_ff <= 1'b0;
    end else if (ackData) begin
      addrPtr_ff <= {addrPtr_ff[7:3], addrPtr_ff[2:0] + 3'd1};
      pageVld_ff[addrPtr_ff[2:0]] <= 1'b1;
      dataSeen_ff <= 1'b1;
    end else if (commitGo) begin
      pageVld_ff <= '0;
      dataSeen_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (ackData) begin
      pageBuf_ff[addrPtr_ff[2:0]] <= rxByte;
    end
  end

  // Commit walker drains valid page entries into the write buffer after stop.
  logic committing_ff;
  logic [3:0] walk_ff;
  logic fifoInReady;
  logic fifoInValid;
  logic [2:0] walkIdx;
  logic [15:0] fifoOut;
  logic fifoOutValid;

  assign commitGo = stopCond && dataSeen_ff && !committing_ff;
  assign walkIdx = walk_ff[2:0];
  assign fifoInValid = committing_ff && pageVldHold_ff[walkIdx];

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      committing_ff <= 1'b0;
      walk_ff <= sew_pkg::BIT_CNT_RST;
      pageVldHold_ff <= '0;
    end else if (commitGo) begin
      committing_ff <= 1'b1;
      walk_ff <= sew_pkg::BIT_CNT_RST;
      pageVldHold_ff <= pageVld_ff;
    end else if (committing_ff && (!fifoInValid || fifoInReady)) begin
      if (walk_ff == 4'(sew_pkg::PAGE_BYTES - 1)) begin
        committing_ff <= 1'b0;
      end
      walk_ff <= walk_ff + 4'd1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wcnt_ff <= sew_pkg::WCNT_RST;
    end else if (commitGo) begin
      wcnt_ff <= sew_pkg::WCNT_LOAD;
    end else if (busy && !committing_ff && !fifoOutValid && !wrValid) begin
      // The timed cycle runs only once every buffered byte has left the array port.
      wcnt_ff <= wcnt_ff - 16'd1;
    end
  end

  sew_fifo u_fifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData({pageBase_ff[7:3], walkIdx, pageBuf_ff[walkIdx]}),
    .outValid(fifoOutValid),
    .outReady(!wrValid || wrReady),
    .outData(fifoOut)
  );

  // Registered array write port toward the storage.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wrValid <= 1'b0;
      wrAddr <= sew_pkg::BYTE_RST;
      wrData <= sew_pkg::BYTE_RST;
      writeBusy <= 1'b0;
    end else begin
      writeBusy <= busy || commitGo;
      if (!wrValid || wrReady) begin
        wrValid <= fifoOutValid;
        wrAddr <= fifoOut[15:8];
        wrData <= fifoOut[7:0];
      end
    end
  end
endmodule : serial_eeprom_write_path
`default_nettype wire

// ==== tb/sew_bus_master.sv ====
`timescale 1ns/1ps
`default_nettype none
module sew_bus_master (
  output logic scl,
  output logic sdaDrv,
  input wire logic sdaWire
);
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end
  task automatic startCond();
    sdaDrv = 1'b1;
    #80 scl = 1'b1;
    #80 sdaDrv = 1'b0;
    #80 scl = 1'b0;
  endtask : startCond
  task automatic stopCond();
    #80 sdaDrv = 1'b0;
    #80 scl = 1'b1;
    #80 sdaDrv = 1'b1;
    #80;
  endtask : stopCond
  task automatic sendByte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= -1; i--) begin
      #80 sdaDrv = (i < 0) ? 1'b1 : b[i];
      #80 scl = 1'b1;
      #80 ack = ~sdaWire;
      #80 scl = 1'b0;
    end
  endtask : sendByte
endmodule : sew_bus_master
`default_nettype wire

// ==== tb/sew_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module sew_checker (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic sclIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic writeBusy,
  input wire logic wrValid,
  input wire logic wrReady,
  input wire logic [7:0] wrAddr,
  input wire logic [7:0] wrData
);
  localparam int CYC = sew_pkg::WRITE_CYCLES;
  logic [15:0] tailCnt_ff;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Counts busy cycles since the last array write was offered.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tailCnt_ff <= 16'h0000;
    end else if (wrValid || !writeBusy) begin
      tailCnt_ff <= 16'h0000;
    end else begin
      tailCnt_ff <= tailCnt_ff + 16'h0001;
    end
  end
  sequence ackHeld;
    sdaOe [*6];
  endsequence
  ack_shape_a: assert property ($rose(sdaOe) |-> ackHeld ##[1:6] !sdaOe)
    else $error("ack pulse length wrong");
  ack_edge_a: assert property ($rose(sdaOe) || $fell(sdaOe) |-> !sclIn)
    else $error("ack changed with clock high");
  busy_quiet_a: assert property (writeBusy |-> !sdaOe)
    else $error("ack while busy");
  drive_low_a: assert property (sdaOut == 1'b0)
    else $error("data drive not low");
  hold_write_a: assert property (wrValid && !wrReady |=> wrValid && $stable(wrAddr) && $stable(wrData))
    else $error("write dropped or changed");
  commit_busy_a: assert property (wrValid |-> writeBusy)
    else $error("write outside cycle");
  busy_length_a: assert property ($fell(writeBusy) |-> tailCnt_ff >= CYC - 2 && tailCnt_ff <= CYC + 2)
    else $error("write cycle length wrong");
  drain_start_a: assert property ($rose(writeBusy) |-> ##[0:20] wrValid)
    else $error("buffer not committed");
endmodule : sew_checker
bind serial_eeprom_write_path sew_checker chk_u (.clk_sys(clk_sys), .arst_n(arst_n),
  .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .writeBusy(writeBusy), .wrValid(wrValid),
  .wrReady(wrReady), .wrAddr(wrAddr), .wrData(wrData));
`default_nettype wire

// ==== tb/serial_eeprom_write_path_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_write_path_tb;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic wrReady = 1'b0;
  logic scl, sdaDrv, sdaOut, sdaOe, writeBusy, wrValid;
  logic [7:0] wrAddr, wrData;
  wire logic sdaWire;
  int mismatches = 0;
  int checks = 0;
  int cyc = 0;
  logic [7:0] gotA[$];
  logic [7:0] gotD[$];
  // Open-drain wire with pull-up: low when either side pulls.
  assign sdaWire = sdaDrv & ~sdaOe;
  always #20 clk_sys = ~clk_sys;
  sew_bus_master m_u (.scl(scl), .sdaDrv(sdaDrv), .sdaWire(sdaWire));
  serial_eeprom_write_path dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .sclIn(scl),
    .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .writeBusy(writeBusy),
    .wrValid(wrValid), .wrReady(wrReady), .wrAddr(wrAddr), .wrData(wrData));
  // The array stalls three cycles in four so the buffer fills.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    wrReady <= (cyc % 4 == 0);
    if (wrValid && wrReady) begin
      gotA.push_back(wrAddr);
      gotD.push_back(wrData);
    end
    if (cyc > 20000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic poll_ready();
    logic ack;
    int tries;
    tries = 0;
    do begin
      m_u.startCond();
      m_u.sendByte({sew_pkg::DEV_CODE, 3'b000, 1'b0}, ack);
      m_u.stopCond();
      if (tries == 0) check("busy nack", 8'h00, 8'(ack));
      tries++;
    end while (!ack && tries < 40);
    check("ready ack", 8'h01, 8'(ack));
    check("idle", 8'h00, 8'(writeBusy));
  endtask : poll_ready
  task automatic page_wrap();
    logic ack;
    m_u.startCond();
    m_u.sendByte({sew_pkg::DEV_CODE, 3'b101, 1'b0}, ack);
    check("ctrl ack", 8'h01, 8'(ack));
    m_u.sendByte(8'h2D, ack);
    check("addr ack", 8'h01, 8'(ack));
    for (int n = 0; n < 10; n++) begin
      m_u.sendByte(8'h40 + 8'(n), ack);
      check("data ack", 8'h01, 8'(ack));
    end
    check("early", 8'h00, 8'(gotA.size()));
    m_u.stopCond();
    poll_ready();
    check("count", 8'h08, 8'(gotA.size()));
    for (int k = 0; k < 8; k++) begin
      check("addr", 8'h28 + 8'(k), gotA[k]);
      check("data", 8'h40 + 8'((k + 3) % 8 + ((k == 5 || k == 6) ? 8 : 0)), gotD[k]);
    end
  endtask : page_wrap
  task automatic refused_and_byte();
    logic ack;
    gotA.delete();
    gotD.delete();
    m_u.startCond();
    m_u.sendByte({~sew_pkg::DEV_CODE, 3'b000, 1'b0}, ack);
    check("foreign nack", 8'h00, 8'(ack));
    m_u.startCond();
    m_u.sendByte({sew_pkg::DEV_CODE, 3'b111, 1'b1}, ack);
    check("read nack", 8'h00, 8'(ack));
    m_u.startCond();
    m_u.sendByte({sew_pkg::DEV_CODE, 3'b010, 1'b0}, ack);
    check("ctrl ack", 8'h01, 8'(ack));
    m_u.sendByte(8'hF7, ack);
    check("addr ack", 8'h01, 8'(ack));
    m_u.sendByte(8'hA5, ack);
    check("byte ack", 8'h01, 8'(ack));
    m_u.stopCond();
    poll_ready();
    check("count", 8'h01, 8'(gotA.size()));
    check("addr", 8'hF7, gotA[0]);
    check("data", 8'hA5, gotD[0]);
  endtask : refused_and_byte
  task automatic close_out();
    $display("Checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    #7;
    page_wrap();
    refused_and_byte();
    close_out();
  end
endmodule : serial_eeprom_write_path_tb
`default_nettype wire
